// File: rtl/ysel_pkg.sv
// Purpose: Constants for the Y operand select and ALU control block.
// Assumes: One clock; nanobits arrive from same-clock control logic.
// Notes: Word bit 15 is the operand MSB, bit 0 the LSB.
// Function
// - Both byte enables zero central bits 1-14.
// - Counter byte enable governs counter high byte.
// - Literal byte enable governs literal low byte.
// - Source 00 B word, 10 counter/literal.
// - Source 01 alternate count, 11 base plus address.
// - MSB control pair sets MSB alone.
// - LSB control pair sets LSB alone.
// - First MSB control held zero elsewhere.
// - Other slices tie second control low/enable.
// - Edge nanobits direct; middle three decoded.
// - MSB code 00 zero, 01 true B.
// - LSB codes zero, true, complement, one.
// - Middle 000 gives zero, 100 gives B.
// - Codes place literal low, counter high.
// - Code 0110101 places counter/literal word.
// - Codes place alternate count, base plus address.
// - Y masking never alters stored B.
// - Deliver sixteen-bit Y operand to ALU.
// - X path selects registers without masking.
// - Mode high arithmetic, low logical operation.
// - Nanobits 27-31 registered into ALU controls.
// - Nanobit 27 high inhibits inter-byte carry.
// - Nanobits 28-31 select the ALU function.
// - Carry in for add-one and subtract.
package ysel_pkg;
   localparam int YSEL_W = 16;
   localparam int YSEL_BYTE_W = 8;
   localparam int YSEL_AMPC_W = 14;
   localparam int YSEL_MSB = 15;
   localparam int YSEL_LSB = 0;
   localparam int YSEL_HI_LO = 8;
   localparam logic [15:0] YSEL_WORD_RST = 16'h0000;
   localparam logic [1:0] YSEL_EDGE_RST = 2'h0;
   localparam logic [2:0] YSEL_MID_RST = 3'h0;
   localparam logic [4:0] YSEL_ALU_RST = 5'h00;
   localparam logic [1:0] YSEL_ENB_RST = 2'h3;
   localparam logic [1:0] YSEL_SLICE_ZERO = 2'h0;
   localparam logic [1:0] YSEL_SLICE_TRUE = 2'h1;
   localparam logic [1:0] YSEL_SLICE_COMP = 2'h2;
   localparam logic [1:0] YSEL_SLICE_ONE = 2'h3;
   localparam logic [2:0] YSEL_MID_ZERO = 3'h0;
   localparam logic [2:0] YSEL_MID_LIT = 3'h1;
   localparam logic [2:0] YSEL_MID_CTR = 3'h3;
   localparam logic [2:0] YSEL_MID_B = 3'h4;
   localparam logic [2:0] YSEL_MID_Z = 3'h5;
   localparam logic [2:0] YSEL_MID_AMPC = 3'h6;
   localparam logic [2:0] YSEL_MID_BMAR = 3'h7;
   localparam logic [2:0] YSEL_X_ZERO = 3'h0;
   localparam logic [2:0] YSEL_X_LIT = 3'h1;
   localparam logic [2:0] YSEL_X_CTR = 3'h3;
   localparam logic [2:0] YSEL_X_Z = 3'h4;
   localparam logic [2:0] YSEL_X_A1 = 3'h5;
   localparam logic [2:0] YSEL_X_A2 = 3'h6;
   localparam logic [2:0] YSEL_X_A3 = 3'h7;
   localparam logic [3:0] YSEL_FN_ADD = 4'h0;
   localparam logic [3:0] YSEL_FN_ADD1 = 4'h3;
   localparam logic [3:0] YSEL_FN_OAD = 4'h5;
   localparam logic [3:0] YSEL_FN_AAD = 4'ha;
   localparam logic [3:0] YSEL_FN_SUB1 = 4'hc;
   localparam logic [3:0] YSEL_FN_SUB = 4'hf;
endpackage

// File: rtl/ysel_ctl_if.sv
// Purpose: Carries registered Y select controls to the gate module.
// Assumes: Driven by flip-flops of the top module.
// Notes: None.
interface ysel_ctl_if;
   logic y_msb_ctl_a;
   logic y_msb_ctl_b;
   logic y_lsb_ctl_a;
   logic y_lsb_ctl_b;
   logic counter_byte_enable;
   logic literal_byte_enable;
   logic y_source_sel_hi;
   logic y_source_sel_lo;
   modport src (output y_msb_ctl_a, y_msb_ctl_b, y_lsb_ctl_a, y_lsb_ctl_b,
                output counter_byte_enable, literal_byte_enable, y_source_sel_hi, y_source_sel_lo);
   modport dst (input y_msb_ctl_a, y_msb_ctl_b, y_lsb_ctl_a, y_lsb_ctl_b,
                input counter_byte_enable, literal_byte_enable, y_source_sel_hi, y_source_sel_lo);
endinterface

// File: rtl/ysel_gates.sv
// Purpose: Combinational Y select gates built from per-bit slices.
// Assumes: Controls come from registers; data inputs are same-clock.
// Notes: An asserted byte enable inhibits its byte of central bits.
module ysel_gates
   import ysel_pkg::*;
(
   ysel_ctl_if.dst ctl,
   input wire logic [15:0] b_reg,
   input wire logic [7:0] counter_reg,
   input wire logic [7:0] literal_reg,
   input wire logic [13:0] alternate_microprogram_count,
   input wire logic [15:0] base_plus_address,
   output logic [15:0] y_word
);
   logic [15:0] src_word;
   logic pass_hi;
   logic pass_lo;

   // One slice: 00 zero, 01 true, 10 complement, 11 one.
   function automatic logic slice_out(input logic ca, input logic cb, input logic d);
      logic r;
      r = 1'b0;
      unique case ({ca, cb})
         YSEL_SLICE_ZERO: r = 1'b0;
         YSEL_SLICE_TRUE: r = d;
         YSEL_SLICE_COMP: r = ~d;
         YSEL_SLICE_ONE: r = 1'b1;
      endcase
      return r;
   endfunction

   // Source choice; B is only read, never written here.
   always_comb
   begin
      unique case ({ctl.y_source_sel_hi, ctl.y_source_sel_lo})
         2'h0: src_word = b_reg;
         2'h2: src_word = {counter_reg, literal_reg};
         2'h1: src_word = {2'h0, alternate_microprogram_count};
         2'h3: src_word = base_plus_address;
      endcase
   end

   // Byte enables mask the central bytes; both together clear them.
   assign pass_hi = ~ctl.counter_byte_enable;
   assign pass_lo = ~ctl.literal_byte_enable;

   // Edge slices take the full control pairs.
   assign y_word[YSEL_MSB] = slice_out(ctl.y_msb_ctl_a, ctl.y_msb_ctl_b, src_word[YSEL_MSB]);
   assign y_word[YSEL_LSB] = slice_out(ctl.y_lsb_ctl_a, ctl.y_lsb_ctl_b, src_word[YSEL_LSB]);

   // Central slices: first control tied low, second to the byte pass.
   genvar i;
   generate
      for (i = 1; i < YSEL_MSB; i++)
      begin : g_central
         if (i >= YSEL_HI_LO)
         begin : g_hi
            assign y_word[i] = slice_out(1'b0, pass_hi & pass_lo | pass_hi & ~pass_lo, src_word[i]);
         end
         else
         begin : g_lo
            assign y_word[i] = slice_out(1'b0, pass_lo & pass_hi | pass_lo & ~pass_hi, src_word[i]);
         end
      end
   endgenerate
endmodule

// File: rtl/ysel_alu_ctl.sv
// Purpose: Y operand select, X select and ALU control register stage.
// Assumes: Nanobit fields and operand registers are on core_clk.
// Notes: Nanobits register at edge k; operands and ALU controls show at k+1.
module ysel_alu_ctl
   import ysel_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [6:0] nano_y_field,
   input wire logic [2:0] nano_x_field,
   input wire logic [4:0] nano_alu_field,
   input wire logic [15:0] b_reg,
   input wire logic [7:0] counter_reg,
   input wire logic [7:0] literal_reg,
   input wire logic [13:0] alternate_microprogram_count,
   input wire logic [15:0] base_reg_one,
   input wire logic [15:0] base_reg_two,
   input wire logic base_reg_sel,
   input wire logic [15:0] memory_address_reg,
   input wire logic [15:0] a_reg_one,
   input wire logic [15:0] a_reg_two,
   input wire logic [15:0] a_reg_three,
   output logic [15:0] y_operand_bus,
   output logic [15:0] x_operand_bus,
   output logic adder_arith_mode,
   output logic [3:0] adder_func_sel,
   output logic alu_carry_in,
   output logic byte_carry_inhibit
);
   ysel_ctl_if ctl ();

   logic [1:0] msb_ctl_ff;
   logic [1:0] nxt_msb_ctl;
   logic [1:0] lsb_ctl_ff;
   logic [1:0] nxt_lsb_ctl;
   logic [1:0] enb_ff;
   logic [1:0] nxt_enb;
   logic [1:0] srcsel_ff;
   logic [1:0] nxt_srcsel;
   logic [2:0] xsel_ff;
   logic [2:0] nxt_xsel;
   logic [4:0] alu_ctl_ff;
   logic [4:0] nxt_alu_ctl;
   logic [15:0] y_ff;
   logic [15:0] nxt_y;
   logic [15:0] x_ff;
   logic [15:0] nxt_x;
   logic mode_ff;
   logic nxt_mode;
   logic [3:0] fsel_ff;
   logic [3:0] nxt_fsel;
   logic cin_ff;
   logic nxt_cin;
   logic inh_ff;
   logic nxt_inh;
   logic [15:0] base_plus_address;
   logic [15:0] y_word;
   logic [2:0] mid;

   assign mid = nano_y_field[4:2];

   // Control register stage: edge nanobits load directly, middle three decode.
   always_comb
   begin
      nxt_msb_ctl = nano_y_field[6:5];
      nxt_lsb_ctl = nano_y_field[1:0];
      nxt_xsel = nano_x_field;
      nxt_alu_ctl = nano_alu_field;
      nxt_enb = 2'h3;
      nxt_srcsel = 2'h0;
      unique case (mid)
         YSEL_MID_ZERO:
         begin
            nxt_enb = 2'h3;
            nxt_srcsel = 2'h0;
         end
         YSEL_MID_LIT:
         begin
            nxt_enb = 2'h2;
            nxt_srcsel = 2'h2;
         end
         YSEL_MID_CTR:
         begin
            nxt_enb = 2'h1;
            nxt_srcsel = 2'h2;
         end
         YSEL_MID_B:
         begin
            nxt_enb = 2'h0;
            nxt_srcsel = 2'h0;
         end
         YSEL_MID_Z:
         begin
            nxt_enb = 2'h0;
            nxt_srcsel = 2'h2;
         end
         YSEL_MID_AMPC:
         begin
            nxt_enb = 2'h0;
            nxt_srcsel = 2'h1;
         end
         YSEL_MID_BMAR:
         begin
            nxt_enb = 2'h0;
            nxt_srcsel = 2'h3;
         end
         default:
         begin
            nxt_enb = 2'h3;
            nxt_srcsel = 2'h0;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         msb_ctl_ff <= YSEL_EDGE_RST;
         lsb_ctl_ff <= YSEL_EDGE_RST;
         enb_ff <= YSEL_ENB_RST;
         srcsel_ff <= YSEL_EDGE_RST;
         xsel_ff <= YSEL_MID_RST;
         alu_ctl_ff <= YSEL_ALU_RST;
      end
      else
      begin
         msb_ctl_ff <= nxt_msb_ctl;
         lsb_ctl_ff <= nxt_lsb_ctl;
         enb_ff <= nxt_enb;
         srcsel_ff <= nxt_srcsel;
         xsel_ff <= nxt_xsel;
         alu_ctl_ff <= nxt_alu_ctl;
      end
   end

   assign ctl.y_msb_ctl_a = msb_ctl_ff[1];
   assign ctl.y_msb_ctl_b = msb_ctl_ff[0];
   assign ctl.y_lsb_ctl_a = lsb_ctl_ff[1];
   assign ctl.y_lsb_ctl_b = lsb_ctl_ff[0];
   assign ctl.counter_byte_enable = enb_ff[1];
   assign ctl.literal_byte_enable = enb_ff[0];
   assign ctl.y_source_sel_hi = srcsel_ff[1];
   assign ctl.y_source_sel_lo = srcsel_ff[0];

   // Chosen base register plus the memory address, kept to sixteen bits.
   assign base_plus_address = (base_reg_sel ? base_reg_two : base_reg_one) + memory_address_reg;

   ysel_gates u_gates (
      .ctl(ctl),
      .b_reg(b_reg),
      .counter_reg(counter_reg),
      .literal_reg(literal_reg),
      .alternate_microprogram_count(alternate_microprogram_count),
      .base_plus_address(base_plus_address),
      .y_word(y_word)
   );

   // Output stage: operands and ALU controls settle together for one cycle.
   always_comb
   begin
      nxt_y = y_word;
      nxt_x = 16'h0000;
      unique case (xsel_ff)
         YSEL_X_LIT: nxt_x = {8'h00, literal_reg};
         YSEL_X_CTR: nxt_x = {counter_reg, 8'h00};
         YSEL_X_Z: nxt_x = {counter_reg, literal_reg};
         YSEL_X_A1: nxt_x = a_reg_one;
         YSEL_X_A2: nxt_x = a_reg_two;
         YSEL_X_A3: nxt_x = a_reg_three;
         default: nxt_x = 16'h0000;
      endcase
      nxt_inh = alu_ctl_ff[4];
      nxt_fsel = alu_ctl_ff[3:0];
      nxt_mode = 1'b0;
      unique case (alu_ctl_ff[3:0])
         YSEL_FN_ADD, YSEL_FN_ADD1, YSEL_FN_OAD, YSEL_FN_AAD, YSEL_FN_SUB1, YSEL_FN_SUB:
            nxt_mode = 1'b1;
         default:
            nxt_mode = 1'b0;
      endcase
      nxt_cin = (alu_ctl_ff[3:0] == YSEL_FN_ADD1) || (alu_ctl_ff[3:0] == YSEL_FN_SUB);
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         y_ff <= YSEL_WORD_RST;
         x_ff <= YSEL_WORD_RST;
         mode_ff <= 1'b0;
         fsel_ff <= 4'h0;
         cin_ff <= 1'b0;
         inh_ff <= 1'b0;
      end
      else
      begin
         y_ff <= nxt_y;
         x_ff <= nxt_x;
         mode_ff <= nxt_mode;
         fsel_ff <= nxt_fsel;
         cin_ff <= nxt_cin;
         inh_ff <= nxt_inh;
      end
   end

   assign y_operand_bus = y_ff;
   assign x_operand_bus = x_ff;
   assign adder_arith_mode = mode_ff;
   assign adder_func_sel = fsel_ff;
   assign alu_carry_in = cin_ff;
   assign byte_carry_inhibit = inh_ff;
endmodule

// File: bench/ysel_nano_src.sv
// Purpose: Nanomemory control word source for the nanobit fields.
// Assumes: The bench changes the word on the falling edge.
// Notes: Word bit 14 is nanobit 17, bit 0 is nanobit 31.
module ysel_nano_src
(
   input wire logic [14:0] nano_word,
   output logic [2:0] nano_x_field,
   output logic [6:0] nano_y_field,
   output logic [4:0] nano_alu_field
);
   assign {nano_x_field, nano_y_field, nano_alu_field} = nano_word;
endmodule

// File: bench/ysel_alu_ctl_asserts.sv
// Purpose: Port assertions for the Y select and ALU control block.
// Assumes: Controls taken at edge k are seen at edge k+2.
// Notes: Checks wait three edges after each reset.
module ysel_alu_ctl_asserts
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [6:0] nano_y_field,
   input wire logic [4:0] nano_alu_field,
   input wire logic [15:0] b_reg,
   input wire logic [7:0] literal_reg,
   input wire logic [13:0] alternate_microprogram_count,
   input wire logic [15:0] y_operand_bus,
   input wire logic adder_arith_mode,
   input wire logic [3:0] adder_func_sel,
   input wire logic alu_carry_in,
   input wire logic byte_carry_inhibit
);
   logic [1:0] age_ff;
   always_ff @(posedge core_clk or negedge resetn)
      if (!resetn)
         age_ff <= 2'h0;
      else if (age_ff != 2'h3)
         age_ff <= age_ff + 2'h1;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!resetn || age_ff != 2'h3);
   sequence s_ycode(logic [6:0] c);
      nano_y_field == c ##2 1'b1;
   endsequence
   sequence s_fn(logic [3:0] f);
      nano_alu_field[3:0] == f ##2 1'b1;
   endsequence
   AST_Y_LIT: assert property (s_ycode(7'h05) |-> y_operand_bus == {8'h00, $past(literal_reg)})
      else $error("literal code gave a wrong operand");
   AST_Y_AMPC: assert property (s_ycode(7'h19) |->
      y_operand_bus == {2'h0, $past(alternate_microprogram_count)})
      else $error("count code gave a wrong operand");
   AST_Y_ZERO: assert property ($past(nano_y_field[4:2], 2) == 3'h0 |-> y_operand_bus[14:1] == 14'h0)
      else $error("central bits not zero");
   AST_Y_B: assert property ($past(nano_y_field[4:2], 2) == 3'h4 |-> y_operand_bus[14:1] == $past(b_reg[14:1]))
      else $error("central bits differ from B");
   AST_MSB_ONE: assert property ($past(nano_y_field[6:5], 2) == 2'h3 |-> y_operand_bus[15])
      else $error("operand top bit not one");
   AST_LSB_COMP: assert property ($past(nano_y_field[4:0], 2) == 5'h12 |-> y_operand_bus[0] == !$past(b_reg[0]))
      else $error("operand low bit not inverted");
   AST_INH: assert property (byte_carry_inhibit == $past(nano_alu_field[4], 2))
      else $error("carry inhibit wrong");
   AST_FN: assert property (adder_func_sel == $past(nano_alu_field[3:0], 2))
      else $error("function select wrong");
   AST_SUB: assert property (s_fn(4'hf) |-> adder_arith_mode && alu_carry_in)
      else $error("subtract controls wrong");
   AST_LOGIC: assert property (s_fn(4'h1) |-> !adder_arith_mode && !alu_carry_in)
      else $error("logic operation controls wrong");
endmodule
bind ysel_alu_ctl ysel_alu_ctl_asserts u_ysel_alu_ctl_asserts (.core_clk(core_clk), .resetn(resetn),
   .nano_y_field(nano_y_field), .nano_alu_field(nano_alu_field), .b_reg(b_reg), .literal_reg(literal_reg),
   .alternate_microprogram_count(alternate_microprogram_count), .y_operand_bus(y_operand_bus),
   .adder_arith_mode(adder_arith_mode), .adder_func_sel(adder_func_sel), .alu_carry_in(alu_carry_in),
   .byte_carry_inhibit(byte_carry_inhibit));

// File: bench/tb.sv
// Purpose: Self-checking bench for the Y select and ALU control block.
// Assumes: Inputs change on the falling edge.
// Notes: Operand values are inverted for a second pass.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] YCODE [6] = '{7'h05, 7'h2c, 7'h35, 7'h19, 7'h3d, 7'h09};
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic [14:0] nano_word = 15'h0000;
   logic [15:0] b_reg = 16'h5aa5;
   logic [7:0] counter_reg = 8'hc3;
   logic [7:0] literal_reg = 8'h3c;
   logic [13:0] alternate_microprogram_count = 14'h2abc;
   logic [15:0] base_reg_one = 16'h1000;
   logic [15:0] base_reg_two = 16'h2000;
   logic base_reg_sel = 1'b1;
   logic [15:0] memory_address_reg = 16'h0123;
   logic [15:0] a_reg_one = 16'h1111;
   logic [15:0] a_reg_two = 16'h2222;
   logic [15:0] a_reg_three = 16'h4444;
   logic [6:0] nano_y_field;
   logic [2:0] nano_x_field;
   logic [4:0] nano_alu_field;
   logic [15:0] y_operand_bus;
   logic [15:0] x_operand_bus;
   logic adder_arith_mode;
   logic [3:0] adder_func_sel;
   logic alu_carry_in;
   logic byte_carry_inhibit;
   int n_fail = 0;
   int n_checks = 0;
   ysel_nano_src u_ysel_nano_src (.nano_word(nano_word), .nano_x_field(nano_x_field),
      .nano_y_field(nano_y_field), .nano_alu_field(nano_alu_field));
   ysel_alu_ctl u_ysel_alu_ctl (.core_clk(core_clk), .resetn(resetn), .nano_y_field(nano_y_field),
      .nano_x_field(nano_x_field), .nano_alu_field(nano_alu_field), .b_reg(b_reg), .counter_reg(counter_reg),
      .literal_reg(literal_reg), .alternate_microprogram_count(alternate_microprogram_count),
      .base_reg_one(base_reg_one), .base_reg_two(base_reg_two), .base_reg_sel(base_reg_sel),
      .memory_address_reg(memory_address_reg), .a_reg_one(a_reg_one), .a_reg_two(a_reg_two),
      .a_reg_three(a_reg_three), .y_operand_bus(y_operand_bus), .x_operand_bus(x_operand_bus),
      .adder_arith_mode(adder_arith_mode), .adder_func_sel(adder_func_sel), .alu_carry_in(alu_carry_in),
      .byte_carry_inhibit(byte_carry_inhibit));
   function automatic logic pick(input logic [1:0] c, input logic v);
      return c == 2'h0 ? 1'b0 : c == 2'h1 ? v : c == 2'h2 ? !v : 1'b1;
   endfunction
   function automatic logic [15:0] y_exp(input logic [6:0] c);
      logic [15:0] s;
      case (c[4:2])
         3'h1: s = {counter_reg[7], 7'h00, literal_reg};
         3'h3: s = {counter_reg, 7'h00, literal_reg[0]};
         3'h4: s = b_reg;
         3'h5: s = {counter_reg, literal_reg};
         3'h6: s = {2'h0, alternate_microprogram_count};
         3'h7: s = (base_reg_sel ? base_reg_two : base_reg_one) + memory_address_reg;
         default: s = {b_reg[15], 14'h0000, b_reg[0]};
      endcase
      return {pick(c[6:5], s[15]), s[14:1], pick(c[1:0], s[0])};
   endfunction
   function automatic logic [15:0] x_exp(input logic [2:0] c);
      case (c)
         3'h1: return {8'h00, literal_reg};
         3'h3: return {counter_reg, 8'h00};
         3'h4: return {counter_reg, literal_reg};
         3'h5: return a_reg_one;
         3'h6: return a_reg_two;
         3'h7: return a_reg_three;
         default: return 16'h0000;
      endcase
   endfunction
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic op(input logic [6:0] y, input logic [2:0] x, input logic [4:0] a);
      @(negedge core_clk);
      nano_word = {x, y, a};
      @(negedge core_clk);
      @(negedge core_clk);
   endtask
   task automatic give_verdict();
      $display("Checks %0d, failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic t_y();
      logic [6:0] c;
      for (int p = 0; p < 2; p++)
      begin
         for (int i = 0; i < 14; i++)
         begin
            c = i < 8 ? {i[1:0], i[2] ? 3'h4 : 3'h0, i[1:0]} : YCODE[i - 8];
            op(c, 3'h0, 5'h00);
            check(y_operand_bus, y_exp(c));
         end
         {b_reg, counter_reg, literal_reg, alternate_microprogram_count, memory_address_reg} =
            ~{b_reg, counter_reg, literal_reg, alternate_microprogram_count, memory_address_reg};
         {base_reg_one, a_reg_one, a_reg_two, a_reg_three} = ~{base_reg_one, a_reg_one, a_reg_two, a_reg_three};
         base_reg_sel = !base_reg_sel;
      end
      $display("Y select test done");
   endtask
   task automatic t_x();
      for (int i = 0; i < 8; i++)
      begin
         op(7'h00, 3'(i), 5'h00);
         check(x_operand_bus, x_exp(3'(i)));
      end
      $display("X select test done");
   endtask
   task automatic t_alu();
      logic [4:0] a;
      for (int i = 0; i < 34; i++)
      begin
         @(negedge core_clk);
         a = 5'(i - 2);
         if (i >= 2)
            check({9'h000, adder_arith_mode, alu_carry_in, byte_carry_inhibit, adder_func_sel},
               {9'h000, a[3:0] inside {4'h0, 4'h3, 4'h5, 4'ha, 4'hc, 4'hf}, a[3:0] inside {4'h3, 4'hf}, a});
         nano_word = {10'h000, 5'(i)};
      end
      $display("ALU control test done");
   endtask
   task automatic t_rst();
      op(7'h35, 3'h4, 5'h1f);
      resetn = 1'b0;
      @(negedge core_clk);
      check(y_operand_bus | x_operand_bus, 16'h0000);
      check({9'h000, adder_arith_mode, alu_carry_in, byte_carry_inhibit, adder_func_sel}, 16'h0000);
      resetn = 1'b1;
      @(negedge core_clk);
      check(y_operand_bus, y_exp(7'h00));
      op(7'h35, 3'h4, 5'h1f);
      check(y_operand_bus, y_exp(7'h35));
      check({9'h000, adder_arith_mode, alu_carry_in, byte_carry_inhibit, adder_func_sel}, 16'h007f);
      $display("Reset test done");
   endtask
   initial
      forever #2.5 core_clk = ~core_clk;
   initial
   begin
      repeat (16) @(posedge core_clk);
      @(negedge core_clk);
      resetn = 1'b1;
      t_y();
      t_x();
      t_alu();
      t_rst();
      give_verdict();
   end
   initial
   begin
      #5000;
      n_fail++;
      $display("Error at %0t: timeout", $time);
      give_verdict();
   end
endmodule
